// *** shared/nax_pkg.sv ***
package nax_pkg;
  // Register byte offsets on the Avalon slave
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_CORE = 5'h04;
  localparam logic [4:0] REG_PTR = 5'h08;
  localparam logic [4:0] REG_PC = 5'h0c;
  localparam logic [4:0] REG_OPC = 5'h10;
  // Field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CORE_WORK_LSB = 0;
  localparam int CORE_EXT_LSB = 4;
  localparam int CORE_CARRY_BIT = 8;
  localparam int CORE_ZERO_BIT = 9;
  localparam int CORE_BUSY_BIT = 10;
  localparam int CORE_SKIP_BIT = 11;
  localparam int PTR_LOW_LSB = 0;
  localparam int PTR_HIGH_LSB = 4;
  localparam int PTR_ALTY_LSB = 8;
  localparam int PTR_ALTX_LSB = 12;
  localparam int PC_LSB = 0;
  localparam int OPC_B2_LSB = 8;
  // Reset values
  localparam logic RUN_RESET = 1'b0;
  localparam logic [11:0] PC_RESET = 12'h000;
  // First opcode byte
  localparam logic [3:0] OPH_IMM_FETCH = 4'h8;
  localparam logic [7:0] OP_PREFIX = 8'hcf;
  localparam logic [7:0] OP_ROT_R = 8'h10;
  localparam logic [7:0] OP_ROT_L = 8'h01;
  localparam logic [7:0] OP_INVERT = 8'h18;
  localparam logic [7:0] OP_CARRY_CLR = 8'h1e;
  localparam logic [7:0] OP_CARRY_SET = 8'h1f;
  localparam logic [7:0] OP_WORK_INC = 8'h14;
  localparam logic [7:0] OP_WORK_DEC = 8'h24;
  localparam logic [7:0] OP_W2E = 8'h45;
  localparam logic [7:0] OP_E2W = 8'h46;
  localparam logic [7:0] OP_SWAP = 8'h44;
  localparam logic [7:0] OP_MINC = 8'h12;
  localparam logic [7:0] OP_MDEC = 8'h22;
  localparam logic [7:0] OP_DINC = 8'hc7;
  localparam logic [7:0] OP_DDEC = 8'hc3;
  localparam logic [5:0] OPH_BSET = 6'h03;
  localparam logic [5:0] OPH_BCLR = 6'h0b;
  localparam logic [7:0] OP_ADDM = 8'h06;
  localparam logic [7:0] OP_ADDD = 8'hc9;
  localparam logic [7:0] OP_ADDC = 8'h02;
  localparam logic [7:0] OP_SUBB = 8'h17;
  localparam logic [7:0] OP_ANDW = 8'h07;
  localparam logic [7:0] OP_ORW = 8'h05;
  localparam logic [7:0] OP_XORW = 8'h15;
  localparam logic [7:0] OP_AND_TO_MEM_OP = 8'h03;
  localparam logic [7:0] OP_ORM = 8'h04;
  localparam logic [7:0] OP_CMPM = 8'h16;
  localparam logic [7:0] OP_PAIR_LD = 8'h5c;
  localparam logic [7:0] OP_PAIR_ST = 8'h5e;
  localparam logic [7:0] OP_DLOAD = 8'hc8;
  localparam logic [7:0] OP_PLOAD_MAIN = 8'h48;
  localparam logic [7:0] OP_PLOAD_ALT = 8'h4a;
  // Second byte after the prefix
  localparam logic [7:0] B2_DFIX_SUM = 8'h26;
  localparam logic [7:0] B2_DFIX_SUB = 8'h2a;
  localparam logic [3:0] B2H_SUMI = 4'h2;
  localparam logic [3:0] B2H_CMPI = 4'ha;
  localparam logic [3:0] B2H_CMPL = 4'h5;
  localparam logic [5:0] B2H_CMPB = 6'h35;
  // Decimal fix addends
  localparam logic [3:0] DFIX_SUM_ADD = 4'h6;
  localparam logic [3:0] DFIX_SUB_ADD = 4'ha;

  typedef enum logic [2:0] {S_IDLE, S_F1, S_F2, S_MR, S_MR2, S_W2} nax_state_t;

  typedef struct packed {
    nax_state_t st;
    logic run;
    logic [11:0] pc;
    logic [7:0] op;
    logic [7:0] b2;
    logic [3:0] work;
    logic [3:0] ext;
    logic carry;
    logic zero;
    logic skip;
    logic [3:0] ptr_high;
    logic [3:0] ptr_low;
    logic [3:0] alt_x;
    logic [3:0] alt_y;
    logic [11:0] rom_addr;
    logic [7:0] mem_addr;
    logic [3:0] mem_wdata;
    logic mem_we;
    logic waitreq;
    logic [31:0] rdata;
  } nax_st_t;

  localparam nax_st_t ST_RESET = '{st: S_IDLE, run: RUN_RESET, pc: PC_RESET,
    waitreq: 1'b1, default: '0};
endpackage

// *** src/nax_core.sv ***
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
// How it works
// - clear work: one byte, loads zero, sets zero bit, skips like immediate load
// - decimal fix: two bytes, adds 6 or 10, zero bit only
// - invert work into ones' complement, update zero bit
// - rotate right through carry, only carry changes
// - rotate left through carry, carry and zero change
// - work to ext and swap keep flags; ext to work sets zero
// - inc/dec memory at main pointer or direct address, zero and carry
// - bit set at main pointer by selector, 11 is bit 3, flags kept
// - bit clear at main pointer, zero bit updated
// - add memory to work, pointer or direct, zero and carry
// - add memory and carry to work, zero and carry
// - add immediate, two bytes, zero only, carry kept
// - memory minus work minus inverted carry; carry one means no borrow
// - AND, OR, XOR into work register, zero updated
// - AND and OR written back to memory, zero updated
// - compare memory with work: greater 0/0, equal 1/1, less 1/0
// - compare work with immediate, two bytes, carry and zero
// - compare low pointer with immediate, zero on equal
// - compare selected bit of work and memory, zero on match
// - pair load/store at even address, work low, ext next, flags kept
// - pointer load uses main pointer or alternate by selector bit
module nax_core
  import nax_pkg::*;
(
  input wire logic mclk, // 10 MHz core clock
  input wire logic rst_b, // Async reset, active low
  input wire logic [4:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  output logic [11:0] rom_addr, // Program address
  input wire logic [7:0] rom_data, // Opcode byte, async read
  output logic [7:0] mem_addr, // Nibble address
  output logic [3:0] mem_wdata, // Nibble to write
  output logic mem_we, // Write strobe
  input wire logic [3:0] mem_rdata // Nibble read, async
);

  nax_st_t s_reg;
  nax_st_t s_next;

  // Four bit add with carry out
  function automatic logic [4:0] add4(input logic [3:0] x, input logic [3:0] y,
                                      input logic ci);
    add4 = {1'b0, x} + {1'b0, y} + {4'h0, ci};
  endfunction

  // Zero test shared by the result zero updates; compares and bus writes set zero directly
  function automatic logic is_zero(input logic [3:0] v);
    is_zero = (v == 4'h0);
  endfunction

  // Bytes that pull a second byte
  function automatic logic two_byte(input logic [7:0] b);
    two_byte = (b == OP_PREFIX) || (b == OP_DINC) || (b == OP_DDEC) ||
               (b == OP_ADDD) || (b == OP_DLOAD);
  endfunction

  logic [7:0] main_ptr;
  logic [7:0] alt_ptr;
  logic [7:0] word_pair;
  logic [3:0] a;
  logic [3:0] m;
  logic [4:0] sum;
  logic [3:0] res;
  logic fin;
  logic [31:0] rv;
  logic [31:0] bm;
  logic [31:0] w;

  // Pointers and the even pair base
  assign main_ptr = {s_reg.ptr_high, s_reg.ptr_low};
  assign alt_ptr = {s_reg.alt_x, s_reg.alt_y};
  assign a = s_reg.work;
  assign m = mem_rdata;

  assign word_pair = {main_ptr[7:1], 1'b0};

  // Register read view
  always_comb begin
    rv = 32'h0000_0000;
    case (avs_address)
      REG_CTRL: rv[CTRL_RUN_BIT] = s_reg.run;
      REG_CORE: begin
        rv[CORE_WORK_LSB +: 4] = s_reg.work;
        rv[CORE_EXT_LSB +: 4] = s_reg.ext;
        rv[CORE_CARRY_BIT] = s_reg.carry;
        rv[CORE_ZERO_BIT] = s_reg.zero;
        rv[CORE_BUSY_BIT] = (s_reg.st != S_IDLE);
        rv[CORE_SKIP_BIT] = s_reg.skip;
      end
      REG_PTR: begin
        rv[PTR_LOW_LSB +: 4] = s_reg.ptr_low;
        rv[PTR_HIGH_LSB +: 4] = s_reg.ptr_high;
        rv[PTR_ALTY_LSB +: 4] = s_reg.alt_y;
        rv[PTR_ALTX_LSB +: 4] = s_reg.alt_x;
      end
      REG_PC: rv[PC_LSB +: 12] = s_reg.pc;
      REG_OPC: begin
        rv[7:0] = s_reg.op;
        rv[OPC_B2_LSB +: 8] = s_reg.b2;
      end
      default: rv = 32'h0000_0000;
    endcase
  end

  // Byte lane merge of a write onto the current view
  always_comb begin
    bm = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
          {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    w = (rv & ~bm) | (avs_writedata & bm);
  end

  // Sequencer and execution
  always_comb begin
    s_next = s_reg;
    s_next.mem_we = 1'b0;
    s_next.waitreq = 1'b1;
    sum = 5'h00;
    res = 4'h0;
    fin = 1'b0;
    case (s_reg.st)
      S_IDLE: begin
        if (s_reg.run) begin
          s_next.st = S_F1;
          s_next.rom_addr = s_reg.pc;
        end
      end
      S_F1: begin
        s_next.op = rom_data;
        s_next.pc = s_reg.pc + 12'h001;
        s_next.skip = 1'b0;
        if (two_byte(rom_data)) begin
          s_next.rom_addr = s_reg.pc + 12'h001;
          s_next.st = S_F2;
        end else if (rom_data[7:4] == OPH_IMM_FETCH) begin
          s_next.skip = 1'b1;
          if (!s_reg.skip) begin
            s_next.work = rom_data[3:0];
            s_next.zero = is_zero(rom_data[3:0]);
          end
          fin = 1'b1;
        end else begin
          fin = 1'b1;
          case (rom_data)
            OP_ROT_R: begin
              s_next.work = {s_reg.carry, a[3:1]};
              s_next.carry = a[0];
            end
            OP_ROT_L: begin
              s_next.work = {a[2:0], s_reg.carry};
              s_next.carry = a[3];
              s_next.zero = is_zero({a[2:0], s_reg.carry});
            end
            OP_INVERT: begin
              s_next.work = ~a;
              s_next.zero = is_zero(~a);
            end
            OP_CARRY_CLR: s_next.carry = 1'b0;
            OP_CARRY_SET: s_next.carry = 1'b1;
            // Work inc or dec, carry out kept
            OP_WORK_INC, OP_WORK_DEC: begin
              sum = add4(a, (rom_data == OP_WORK_INC) ? 4'h1 : 4'hf, 1'b0);
              s_next.work = sum[3:0];
              s_next.carry = sum[4];
              s_next.zero = is_zero(sum[3:0]);
            end
            OP_W2E: s_next.ext = a;
            OP_SWAP: begin
              s_next.ext = a;
              s_next.work = s_reg.ext;
            end
            OP_E2W: begin
              s_next.work = s_reg.ext;
              s_next.zero = is_zero(s_reg.ext);
            end
            OP_PAIR_ST: begin
              s_next.mem_addr = word_pair;
              s_next.mem_wdata = a;
              s_next.mem_we = 1'b1;
              s_next.st = S_W2;
              fin = 1'b0;
            end
            OP_PLOAD_ALT, OP_PAIR_LD: begin
              s_next.mem_addr = (rom_data == OP_PAIR_LD) ? word_pair : alt_ptr;
              s_next.st = S_MR;
              fin = 1'b0;
            end
            OP_MINC, OP_MDEC, OP_ADDM, OP_ADDC, OP_SUBB, OP_ANDW, OP_ORW,
            OP_XORW, OP_AND_TO_MEM_OP, OP_ORM, OP_CMPM, OP_PLOAD_MAIN: begin
              s_next.mem_addr = main_ptr;
              s_next.st = S_MR;
              fin = 1'b0;
            end
            default: begin
              if (rom_data[7:2] == OPH_BSET || rom_data[7:2] == OPH_BCLR) begin
                s_next.mem_addr = main_ptr;
                s_next.st = S_MR;
                fin = 1'b0;
              end
            end
          endcase
        end
      end
      S_F2: begin
        s_next.b2 = rom_data;
        s_next.pc = s_reg.pc + 12'h001;
        fin = 1'b1;
        if (s_reg.op == OP_PREFIX) begin
          if (rom_data == B2_DFIX_SUM || rom_data == B2_DFIX_SUB) begin
            sum = add4(a, (rom_data == B2_DFIX_SUM) ? DFIX_SUM_ADD : DFIX_SUB_ADD,
                       1'b0);
            s_next.work = sum[3:0];
            s_next.zero = is_zero(sum[3:0]);
          end else if (rom_data[7:4] == B2H_SUMI) begin
            sum = add4(a, rom_data[3:0], 1'b0);
            s_next.work = sum[3:0];
            s_next.zero = is_zero(sum[3:0]);
          end else if (rom_data[7:4] == B2H_CMPI) begin
            s_next.carry = !(rom_data[3:0] > a);
            s_next.zero = (rom_data[3:0] == a);
          end else if (rom_data[7:4] == B2H_CMPL) begin
            s_next.zero = (s_reg.ptr_low == rom_data[3:0]);
          end else if (rom_data[7:2] == B2H_CMPB) begin
            s_next.mem_addr = main_ptr;
            s_next.st = S_MR;
            fin = 1'b0;
          end
        end else begin
          s_next.mem_addr = rom_data;
          s_next.st = S_MR;
          fin = 1'b0;
        end
      end
      S_MR: begin
        fin = 1'b1;
        case (s_reg.op)
          // inc or dec, carry is carry out on inc, no borrow on dec
          OP_MINC, OP_DINC, OP_MDEC, OP_DDEC: begin
            sum = add4(m, (s_reg.op == OP_MINC || s_reg.op == OP_DINC) ? 4'h1 : 4'hf, 1'b0);
            s_next.mem_wdata = sum[3:0];
            s_next.mem_we = 1'b1;
            s_next.carry = sum[4];
            s_next.zero = is_zero(sum[3:0]);
          end
          OP_ADDM, OP_ADDD, OP_ADDC: begin
            sum = add4(a, m, (s_reg.op == OP_ADDC) & s_reg.carry);
            s_next.work = sum[3:0];
            s_next.carry = sum[4];
            s_next.zero = is_zero(sum[3:0]);
          end
          // m plus not a plus carry
          OP_SUBB: begin
            sum = add4(m, ~a, s_reg.carry);
            s_next.work = sum[3:0];
            s_next.carry = sum[4];
            s_next.zero = is_zero(sum[3:0]);
          end
          OP_ANDW, OP_ORW, OP_XORW: begin
            res = (s_reg.op == OP_ANDW) ? (a & m) :
                  (s_reg.op == OP_ORW) ? (a | m) : (a ^ m);
            s_next.work = res;
            s_next.zero = is_zero(res);
          end
          OP_AND_TO_MEM_OP, OP_ORM: begin
            res = (s_reg.op == OP_AND_TO_MEM_OP) ? (a & m) : (a | m);
            s_next.mem_wdata = res;
            s_next.mem_we = 1'b1;
            s_next.zero = is_zero(res);
          end
          OP_CMPM: begin
            s_next.carry = !(m > a);
            s_next.zero = (m == a);
          end
          OP_DLOAD, OP_PLOAD_MAIN, OP_PLOAD_ALT: begin
            s_next.work = m;
            s_next.zero = is_zero(m);
          end
          OP_PAIR_LD: begin
            s_next.work = m;
            s_next.mem_addr = {word_pair[7:1], 1'b1};
            s_next.st = S_MR2;
            fin = 1'b0;
          end
          OP_PREFIX: s_next.zero = (a[s_reg.b2[1:0]] == m[s_reg.b2[1:0]]);
          default: begin
            res = m;
            if (s_reg.op[7:2] == OPH_BSET) begin
              res[s_reg.op[1:0]] = 1'b1;
            end else begin
              res[s_reg.op[1:0]] = 1'b0;
              s_next.zero = is_zero(res);
            end
            s_next.mem_wdata = res;
            s_next.mem_we = 1'b1;
          end
        endcase
      end
      S_MR2: begin
        s_next.ext = m;
        fin = 1'b1;
      end
      S_W2: begin
        s_next.mem_addr = {word_pair[7:1], 1'b1};
        s_next.mem_wdata = s_reg.ext;
        s_next.mem_we = 1'b1;
        fin = 1'b1;
      end
      default: s_next.st = S_IDLE;
    endcase

    // Halt only on instruction boundaries
    if (fin) begin
      s_next.rom_addr = s_next.pc;
      s_next.st = s_reg.run ? S_F1 : S_IDLE;
    end

    // Avalon slave, one wait state; bus write wins over the core
    if ((avs_read || avs_write) && s_reg.waitreq) begin
      s_next.waitreq = 1'b0;
      s_next.rdata = avs_read ? rv : s_reg.rdata;
    end else if (avs_write && !s_reg.waitreq) begin
      case (avs_address)
        REG_CTRL: s_next.run = w[CTRL_RUN_BIT];
        REG_CORE: begin
          s_next.work = w[CORE_WORK_LSB +: 4];
          s_next.ext = w[CORE_EXT_LSB +: 4];
          s_next.carry = w[CORE_CARRY_BIT];
          s_next.zero = w[CORE_ZERO_BIT];
        end
        REG_PTR: begin
          s_next.ptr_low = w[PTR_LOW_LSB +: 4];
          s_next.ptr_high = w[PTR_HIGH_LSB +: 4];
          s_next.alt_y = w[PTR_ALTY_LSB +: 4];
          s_next.alt_x = w[PTR_ALTX_LSB +: 4];
        end
        REG_PC: s_next.pc = w[PC_LSB +: 12];
        default: s_next.run = s_next.run;
      endcase
    end
  end

  // All state in one register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= ST_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata = s_reg.rdata;
  assign avs_waitrequest = s_reg.waitreq;
  assign rom_addr = s_reg.rom_addr;
  assign mem_addr = s_reg.mem_addr;
  assign mem_wdata = s_reg.mem_wdata;
  assign mem_we = s_reg.mem_we;

endmodule

// *** bench/nax_core_checker.sv ***
`timescale 1ns/1ps
module nax_core_checker
  import nax_pkg::*;
(
  input wire logic mclk, // Core clock
  input wire logic rst_b, // Async reset
  input wire logic [4:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Lanes
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest, // Stall
  input wire logic [11:0] rom_addr, // Program address
  input wire logic [7:0] rom_data, // Opcode byte
  input wire logic [7:0] mem_addr, // Nibble address
  input wire logic [3:0] mem_wdata, // Write nibble
  input wire logic mem_we, // Write strobe
  input wire logic [3:0] mem_rdata // Read nibble
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic mapped;
  // Full decode, so aliases of a register must read as holes
  assign mapped = avs_address inside {REG_CTRL, REG_CORE, REG_PTR, REG_PC, REG_OPC};

  // Bus answers after exactly one wait state
  wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  wait_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("waitrequest dropped without a request");
  read_hold_a: assert property ($changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (avs_read && avs_waitrequest && !mapped |=> avs_readdata == 32'h0)
    else $error("hole read not zero");
  // Memory strobe: single pulses, or the pair store burst of two
  we_burst_a: assert property (mem_we ##1 mem_we |=> !mem_we)
    else $error("write strobe longer than two cycles");
  pair_addr_a: assert property (mem_we && $past(mem_we) |->
    !$past(mem_addr[0]) && mem_addr == {$past(mem_addr[7:1]), 1'b1})
    else $error("pair store not on even then odd address");
  reset_out_a: assert property ($rose(rst_b) |->
    avs_waitrequest && !mem_we && avs_readdata == 32'h0 && rom_addr == 12'h000)
    else $error("outputs not at reset values");
  // Main scenarios reached
  read_done_c: cover property (avs_read && !avs_waitrequest);
  pair_store_c: cover property (mem_we ##1 mem_we);
  hole_write_c: cover property (avs_write && !avs_waitrequest && !mapped);
endmodule

bind nax_core nax_core_checker u_chk (.mclk(mclk), .rst_b(rst_b),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .rom_addr(rom_addr), .rom_data(rom_data), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(mem_rdata));

// *** bench/nax_mem_model.sv ***
`timescale 1ns/1ps
module nax_mem_model (
  input wire logic mclk, // Core clock
  input wire logic [11:0] rom_addr, // Program address
  output logic [7:0] rom_data, // Opcode byte
  input wire logic [7:0] mem_addr, // Nibble address
  input wire logic [3:0] mem_wdata, // Write nibble
  input wire logic mem_we, // Write strobe
  output logic [3:0] mem_rdata // Read nibble
);
  logic [7:0] rom [4096];
  logic [3:0] ram [256];
  // Blank program is a stream of undefined no-ops
  initial begin
    foreach (rom[i]) rom[i] = 8'h00;
    foreach (ram[i]) ram[i] = 4'h0;
  end
  // Both reads are asynchronous, as the core expects
  assign rom_data = rom[rom_addr];
  assign mem_rdata = ram[mem_addr];
  // Write lands at the edge ending the strobe cycle
  always @(posedge mclk) begin
    if (mem_we) begin
      ram[mem_addr] <= mem_wdata;
    end
  end
endmodule

// *** bench/tb_nibble_alu_instruction_exec.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((e) !== (g)) begin \
      mismatches++; \
      $display("wrong value %s expected %h seen %h", nm, e, g); \
    end \
  end
module tb_nibble_alu_instruction_exec
  import nax_pkg::*;
;
  logic mclk, rst_b, avs_read, avs_write, avs_waitrequest, mem_we;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable, mem_wdata, mem_rdata;
  logic [11:0] rom_addr;
  logic [7:0] rom_data, mem_addr;
  logic [15:0] pv;
  int mismatches, samples_checked;

  nax_core u_dut (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rom_addr(rom_addr), .rom_data(rom_data),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(mem_rdata));
  nax_mem_model u_mem (.mclk(mclk), .rom_addr(rom_addr), .rom_data(rom_data),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(mem_rdata));

  // 10 MHz core clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    for (int n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    if (avs_waitrequest !== 1'b0) mismatches++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic setm(input logic [7:0] a, input logic [3:0] v);
    u_mem.ram[a] = v;
  endtask

  // Run from 0x100 for a few cycles, so a one byte op at 0x100 is followed by 0x101; halt, wait for idle, judge the core word
  task automatic op(input logic [7:0] a, b, input logic [9:0] c, e);
    u_mem.rom[12'h100] = a;
    u_mem.rom[12'h101] = b;
    xfer(1'b1, REG_PTR, {16'h0, pv});
    xfer(1'b1, REG_CORE, {22'h0, c});
    xfer(1'b1, REG_PC, 32'h100);
    xfer(1'b1, REG_CTRL, 32'h1);
    xfer(1'b1, REG_CTRL, 32'h0);
    for (int n = 0; n < 20; n++) begin
      xfer(1'b0, REG_CORE, 32'h0);
      if (rd[CORE_BUSY_BIT] === 1'b0) break;
    end
    `CHK("core", e, rd[9:0])
  endtask

  // Reset values, hole, read-only word and lane merge
  task automatic t_bus;
    xfer(1'b0, REG_PC, 32'h0);
    `CHK("pc", 32'h0, rd)
    xfer(1'b1, 5'h14, 32'hffffffff);
    xfer(1'b0, 5'h14, 32'h0);
    `CHK("hole", 32'h0, rd)
    xfer(1'b1, REG_OPC, 32'hffff);
    xfer(1'b0, REG_OPC, 32'h0);
    `CHK("opc", 32'h0, rd)
    avs_byteenable <= 4'h1;
    xfer(1'b1, REG_PTR, 32'hffff);
    avs_byteenable <= 4'hf;
    xfer(1'b0, REG_PTR, 32'h0);
    `CHK("ptr", 32'hff, rd)
  endtask

  task automatic t_acc;
    op(8'h80, 8'h00, 10'h005, 10'h200);
    op(8'h18, 8'h00, 10'h10a, 10'h105);
    op(8'h10, 8'h00, 10'h203, 10'h301);
    op(8'h01, 8'h00, 10'h008, 10'h300);
    op(8'h01, 8'h00, 10'h304, 10'h009);
    op(8'hcf, 8'h26, 10'h105, 10'h10b);
    op(8'hcf, 8'h2a, 10'h006, 10'h200);
    op(8'hcf, 8'h23, 10'h00e, 10'h001);
    op(8'h45, 8'h00, 10'h307, 10'h377);
    op(8'h44, 8'h00, 10'h2a3, 10'h23a);
    op(8'h46, 8'h00, 10'h003, 10'h200);
    op(8'h1f, 8'h00, 10'h000, 10'h100);
    op(8'h1e, 8'h00, 10'h105, 10'h005);
    op(8'h14, 8'h00, 10'h00f, 10'h300);
    op(8'h24, 8'h00, 10'h300, 10'h00f);
  endtask

  task automatic t_mem;
    setm(8'h2f, 4'hf);
    op(8'h12, 8'h00, 10'h000, 10'h300);
    `CHK("ram", 4'h0, u_mem.ram[8'h2f])
    setm(8'h40, 4'h0);
    op(8'hc3, 8'h40, 10'h300, 10'h000);
    `CHK("ram", 4'hf, u_mem.ram[8'h40])
    op(8'h0f, 8'h00, 10'h300, 10'h300);
    op(8'h0c, 8'h00, 10'h000, 10'h000);
    `CHK("ram", 4'h9, u_mem.ram[8'h2f])
    op(8'h2f, 8'h00, 10'h200, 10'h000);
    op(8'h2c, 8'h00, 10'h000, 10'h200);
    `CHK("ram", 4'h0, u_mem.ram[8'h2f])
    op(8'h22, 8'h00, 10'h300, 10'h000);
    `CHK("ram", 4'hf, u_mem.ram[8'h2f])
    setm(8'h41, 4'h7);
    op(8'hc7, 8'h41, 10'h300, 10'h000);
    `CHK("ram", 4'h8, u_mem.ram[8'h41])
    setm(8'h2f, 4'ha);
    op(8'h03, 8'h00, 10'h20c, 10'h00c);
    op(8'h04, 8'h00, 10'h003, 10'h003);
    `CHK("ram", 4'hb, u_mem.ram[8'h2f])
  endtask

  task automatic t_arith;
    setm(8'h2f, 4'h8);
    op(8'h06, 8'h00, 10'h009, 10'h101);
    setm(8'h50, 4'h7);
    op(8'hc9, 8'h50, 10'h101, 10'h008);
    op(8'h02, 8'h00, 10'h107, 10'h300);
    setm(8'h2f, 4'h3);
    op(8'h17, 8'h00, 10'h105, 10'h00e);
    setm(8'h2f, 4'h5);
    op(8'h17, 8'h00, 10'h002, 10'h102);
    setm(8'h2f, 4'ha);
    op(8'h07, 8'h00, 10'h005, 10'h200);
    op(8'h05, 8'h00, 10'h205, 10'h00f);
    op(8'h15, 8'h00, 10'h00a, 10'h200);
  endtask

  task automatic t_cmp;
    setm(8'h2f, 4'h9);
    op(8'h16, 8'h00, 10'h304, 10'h004);
    setm(8'h2f, 4'h4);
    op(8'h16, 8'h00, 10'h004, 10'h304);
    setm(8'h2f, 4'h2);
    op(8'h16, 8'h00, 10'h204, 10'h104);
    op(8'hcf, 8'ha9, 10'h304, 10'h004);
    op(8'hcf, 8'ha4, 10'h004, 10'h304);
    op(8'hcf, 8'ha2, 10'h204, 10'h104);
    op(8'hcf, 8'h5f, 10'h000, 10'h200);
    op(8'hcf, 8'h5e, 10'h300, 10'h100);
    setm(8'h2f, 4'h9);
    op(8'hcf, 8'hd7, 10'h008, 10'h208);
    op(8'hcf, 8'hd4, 10'h208, 10'h008);
    op(8'hcf, 8'hd5, 10'h008, 10'h208);
  endtask

  task automatic t_load;
    pv = 16'h3123;
    op(8'h5e, 8'h00, 10'h396, 10'h396);
    `CHK("ram", 4'h6, u_mem.ram[8'h22])
    `CHK("ram", 4'h9, u_mem.ram[8'h23])
    setm(8'h22, 4'h1);
    setm(8'h23, 4'h2);
    op(8'h5c, 8'h00, 10'h300, 10'h321);
    pv = 16'h312f;
    op(8'h85, 8'h00, 10'h200, 10'h005);
    op(8'h85, 8'h87, 10'h000, 10'h005);
    setm(8'h60, 4'h0);
    op(8'hc8, 8'h60, 10'h00f, 10'h200);
    setm(8'h2f, 4'hc);
    setm(8'h31, 4'h0);
    op(8'h48, 8'h00, 10'h200, 10'h00c);
    op(8'h4a, 8'h00, 10'h00c, 10'h200);
  endtask

  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_b = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    pv = 16'h312f;
    mismatches = 0;
    samples_checked = 0;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    t_bus();
    t_acc();
    t_mem();
    t_arith();
    t_cmp();
    t_load();
    results();
  end

  // Hang guard, well past the thousand or so cycles expected
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    results();
  end
endmodule
